// >>> rtl/fsw_cfg.svh
// constants for the flash status and write latch block
`ifndef FSW_CFG_SVH
`define FSW_CFG_SVH
// Behaviour
// RL1: write-lock command clears the latch; writes, programs, erases then refused.
// RL2: host frames write-lock as select low, opcode byte, select high.
// RL3: latch clears at power-up and on completion of any write-type command.
// RL4: write-unlock sets the latch; register update never sets it.
// RL5: status read is taken at any time, even while busy.
// RL6: status byte repeats on serial output while select stays low.
// RL7: host should poll busy before new commands during an operation.
// RL8: status bit 0 is read-only busy, set during update, program, erase.
// RL9: status bit 1 shows the latch; zero refuses update, program, erase.
// RL10: status bits 4..2 are the guard field, written by register update.
// RL11: nonzero guard field refuses program and erase into the guarded region.
// RL12: whole-array wipe only with guard field zero; guard resets to 000.
// RL13: status bit 5 flags a failed erase until flag-clear command.
// RL14: status bit 6 flags a failed program until flag-clear command.
// RL15: refused attempts on guarded regions set neither error flag.
// RL16: lock bit 7 with protect pin low locks registers, refuses update.
// RL17: lock bit zero gives no register protection even with pin low.
// RL18: config read shifts the config byte out, taken at any time.
// RL19: config register reads all zeros from delivery.
// RL20: register update needs exactly 8 or 16 data bits, else cancelled.
// RL21: register update leaves error and busy flags; reserved bits read 0.
// RL22: opcode decoded after 8 bits; latch effects at select rising edge.

// status bit positions
`define FSW_BIT_BUSY 0
`define FSW_BIT_LATCH 1
`define FSW_BIT_GUARD_LO 2
`define FSW_BIT_GUARD_HI 4
`define FSW_BIT_EERR 5
`define FSW_BIT_PERR 6
`define FSW_BIT_LOCK 7

// reset values
`define FSW_GUARD_RST 3'h0
`define FSW_CONFIG_RST 8'h00

// opcodes
`define FSW_OP_WRITE_UNLOCK 8'h06
`define FSW_OP_WRITE_LOCK 8'h04
`define FSW_OP_STATE_READ 8'h05
`define FSW_OP_CONFIG_READ 8'h35
`define FSW_OP_REGISTER_UPDATE 8'h01
`define FSW_OP_FLAG_CLEAR 8'h30
`define FSW_OP_PAGE_WRITE 8'h02
`define FSW_OP_FOUR_LANE 8'h32
`define FSW_OP_ONETIME 8'h42
`define FSW_OP_WIPE4K 8'h20
`define FSW_OP_WIPE8K 8'h40
`define FSW_OP_BLOCK_WIPE 8'hD8
`define FSW_OP_WHOLE_WIPE 8'hC7

// frame bit counts
`define FSW_CNT_OP 6'h08
`define FSW_CNT_ONE_BYTE 6'h10
`define FSW_CNT_TWO_BYTES 6'h18
`define FSW_CNT_ADDR 6'h20
`define FSW_CNT_MAX 6'h3F

// timing
`define FSW_CLK_MHZ 200
`define FSW_UPD_TIME_NS 1000
`define FSW_UPD_CYCLES ((`FSW_UPD_TIME_NS * `FSW_CLK_MHZ + 999) / 1000)
`endif

// >>> rtl/fsw_pkg.sv
// types for the flash status and write latch block
package fsw_pkg;
  typedef enum logic [1:0] {
    fsw_idle = 2'h0,
    fsw_upd = 2'h1,
    fsw_job = 2'h2
  } fsw_state_t;

  typedef enum logic [2:0] {
    fsw_job_page = 3'h0,
    fsw_job_quad = 3'h1,
    fsw_job_ota = 3'h2,
    fsw_job_w4k = 3'h3,
    fsw_job_w8k = 3'h4,
    fsw_job_block = 3'h5,
    fsw_job_whole = 3'h6
  } fsw_job_t;
endpackage

// >>> rtl/fsw_sync.sv
// two-flop level synchroniser, one per bit
module fsw_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // levels
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_r <= '0;
      sync_r <= '0;
    end else if (ce_in) begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;
endmodule // fsw_sync

// >>> rtl/fsw_core.sv
// status register, write latch and protection logic of a serial flash
`include "fsw_cfg.svh"

module fsw_core import fsw_pkg::*; #(
  parameter int UPD_CYCLES = `FSW_UPD_CYCLES
) (
  // system clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // serial link pins
  input wire logic sck_in,
  input wire logic cs_b_in,
  input wire logic si_in,
  output logic so_out,
  output logic so_oe_out,
  input wire logic write_protect_pin_b_in,
  // program and erase engine
  output logic job_go_out,
  output logic [2:0] job_kind_out,
  output logic [23:0] job_addr_out,
  input wire logic addr_guarded_in,
  input wire logic job_done_in,
  input wire logic job_fail_in,
  // register view
  output logic [7:0] flash_state_flags_out,
  output logic [7:0] config_out,
  output logic hw_lock_state_out
);

  // ---------------- link domain (serial clock) ----------------
  logic frm_rst_b;
  logic lk_live_r;
  logic [5:0] lk_cnt_r;
  logic [2:0] lk_ph_r;
  logic [7:0] lk_sh_r;
  logic [7:0] lk_op_r;
  logic [23:0] lk_pl_r;
  logic [7:0] lk_stat;
  logic [7:0] lk_cfg;
  logic [7:0] lk_sel;
  logic [7:0] lk_byte_r;
  logic lk_so_r;
  logic lk_oe_r;
  logic lk_rd;

  // frame state drops the moment select rises; sck may stop after it
  assign frm_rst_b = rst_b_in & ~cs_b_in;

  always_ff @(posedge sck_in or negedge frm_rst_b) begin
    if (!frm_rst_b) begin
      lk_live_r <= 1'b0;
    end else begin
      lk_live_r <= 1'b1;
    end
  end

  // counters restart on the first edge of each frame, and keep their
  // value after it so the system side can decode the finished frame
  always_ff @(posedge sck_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lk_cnt_r <= 6'h00;
      lk_ph_r <= 3'h0;
    end else if (!lk_live_r) begin
      lk_cnt_r <= 6'h01;
      lk_ph_r <= 3'h1;
    end else begin
      if (lk_cnt_r != `FSW_CNT_MAX) begin
        lk_cnt_r <= lk_cnt_r + 6'h01;
      end
      lk_ph_r <= lk_ph_r + 3'h1;
    end
  end

  always_ff @(posedge sck_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lk_sh_r <= 8'h00;
      lk_op_r <= 8'h00;
      lk_pl_r <= 24'h000000;
    end else begin
      if (!lk_live_r) begin
        lk_sh_r <= {7'h00, si_in};
      end else begin
        lk_sh_r <= {lk_sh_r[6:0], si_in};
      end
      if (lk_live_r && lk_cnt_r == `FSW_CNT_OP - 6'h01) begin
        lk_op_r <= {lk_sh_r[6:0], si_in}; // RL22
      end
      if (lk_live_r && lk_cnt_r >= `FSW_CNT_OP &&
          lk_cnt_r < `FSW_CNT_ADDR) begin
        lk_pl_r <= {lk_pl_r[22:0], si_in};
      end
    end
  end

  // flags are independent levels; a byte is snapshotted per pass so
  // that one output byte never mixes old and new values
  fsw_sync #(
    .W(16)
  ) u_lk_sync (
    .clk_in(sck_in),
    .rst_b_in(rst_b_in),
    .ce_in(1'b1),
    .d_in({flash_state_flags_out, config_out}),
    .q_out({lk_stat, lk_cfg})
  );

  assign lk_rd = (lk_op_r == `FSW_OP_STATE_READ) ||
                 (lk_op_r == `FSW_OP_CONFIG_READ); // RL5 RL18
  assign lk_sel = (lk_op_r == `FSW_OP_STATE_READ) ? lk_stat : lk_cfg;

  // output changes on the falling edge, msb first, repeating per byte
  always_ff @(negedge sck_in or negedge frm_rst_b) begin
    if (!frm_rst_b) begin
      lk_so_r <= 1'b0;
      lk_oe_r <= 1'b0;
      lk_byte_r <= 8'h00;
    end else if (lk_live_r && lk_cnt_r >= `FSW_CNT_OP && lk_rd) begin
      lk_oe_r <= 1'b1;
      if (lk_ph_r == 3'h0) begin
        lk_byte_r <= lk_sel; // RL6
        lk_so_r <= lk_sel[7];
      end else begin
        lk_so_r <= lk_byte_r[3'h7 - lk_ph_r]; // RL6
      end
    end
  end

  assign so_out = lk_so_r;
  assign so_oe_out = lk_oe_r;

  // ---------------- system domain ----------------
  logic sel_s;
  logic wp_low_s;
  logic cs_d_r;
  logic frame_end;
  fsw_state_t state_r;
  fsw_state_t state_nxt;
  logic [15:0] upd_tmr_r;
  logic latch_r;
  logic [2:0] guard_r;
  logic lock_r;
  logic perr_r;
  logic eerr_r;
  logic [7:0] cfg_r;
  logic job_pend_r;
  fsw_job_t job_kind_r;
  logic [23:0] job_addr_r;
  logic job_go_r;
  logic hw_lock;
  logic idle;
  logic op_byte_only;
  logic cmd_unlock;
  logic cmd_lock;
  logic cmd_clear;
  logic upd_len_ok;
  logic upd_ok;
  logic job_cmd;
  fsw_job_t job_cmd_kind;
  logic job_blocked;
  logic launch;
  logic upd_done;
  logic job_done;
  logic job_is_prog;

  // pins synced active high: the flop reset value reads as deselected
  // and unprotected, so no false frame end follows reset
  fsw_sync #(
    .W(2)
  ) u_pin_sync (
    .clk_in(clock_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .d_in({~cs_b_in, ~write_protect_pin_b_in}),
    .q_out({sel_s, wp_low_s})
  );

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cs_d_r <= 1'b0;
    end else if (ce_in) begin
      cs_d_r <= sel_s;
    end
  end

  // link words are stable here: sck is quiet once select is high
  assign frame_end = ce_in & ~sel_s & cs_d_r; // RL22
  assign op_byte_only = frame_end && lk_cnt_r == `FSW_CNT_OP;
  assign idle = (state_r == fsw_idle);
  assign hw_lock = lock_r & wp_low_s; // RL16 RL17

  assign cmd_unlock = op_byte_only && lk_op_r == `FSW_OP_WRITE_UNLOCK;
  assign cmd_lock = op_byte_only && lk_op_r == `FSW_OP_WRITE_LOCK;
  assign cmd_clear = op_byte_only && lk_op_r == `FSW_OP_FLAG_CLEAR;

  assign upd_len_ok = (lk_cnt_r == `FSW_CNT_ONE_BYTE) ||
                      (lk_cnt_r == `FSW_CNT_TWO_BYTES); // RL20
  assign upd_ok = frame_end && lk_op_r == `FSW_OP_REGISTER_UPDATE &&
                  upd_len_ok && latch_r && idle && !hw_lock; // RL9 RL16

  always_comb begin
    job_cmd = 1'b0;
    job_cmd_kind = fsw_job_page;
    if (frame_end && lk_cnt_r >= `FSW_CNT_ADDR) begin
      job_cmd = 1'b1;
      case (lk_op_r)
        `FSW_OP_PAGE_WRITE: job_cmd_kind = fsw_job_page;
        `FSW_OP_FOUR_LANE: job_cmd_kind = fsw_job_quad;
        `FSW_OP_ONETIME: job_cmd_kind = fsw_job_ota;
        `FSW_OP_WIPE4K: job_cmd_kind = fsw_job_w4k;
        `FSW_OP_WIPE8K: job_cmd_kind = fsw_job_w8k;
        `FSW_OP_BLOCK_WIPE: job_cmd_kind = fsw_job_block;
        default: job_cmd = 1'b0;
      endcase
    end else if (op_byte_only && lk_op_r == `FSW_OP_WHOLE_WIPE) begin
      job_cmd = 1'b1;
      job_cmd_kind = fsw_job_whole;
    end
  end

  // request is parked one cycle so the region check sees a stable address
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      job_pend_r <= 1'b0;
      job_kind_r <= fsw_job_page;
      job_addr_r <= 24'h000000;
    end else if (ce_in) begin
      if (job_cmd && idle && !job_pend_r) begin
        job_pend_r <= 1'b1;
        job_kind_r <= job_cmd_kind;
        job_addr_r <= lk_pl_r;
      end else begin
        job_pend_r <= 1'b0;
      end
    end
  end

  // whole wipe needs an empty guard field; one-time area is not guarded
  always_comb begin
    case (job_kind_r)
      fsw_job_whole: job_blocked = (guard_r != 3'h0); // RL12
      fsw_job_ota: job_blocked = 1'b0;
      default: job_blocked = addr_guarded_in; // RL11
    endcase
  end

  assign launch = ce_in && job_pend_r && latch_r && idle &&
                  !job_blocked; // RL1 RL9 RL11 RL15

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      job_go_r <= 1'b0;
    end else if (ce_in) begin
      job_go_r <= launch;
    end
  end

  assign upd_done = (state_r == fsw_upd) && (upd_tmr_r == 16'h0001);
  assign job_done = (state_r == fsw_job) && job_done_in;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      fsw_idle: begin
        if (upd_ok) begin
          state_nxt = fsw_upd;
        end else if (launch) begin
          state_nxt = fsw_job;
        end
      end
      fsw_upd: begin
        if (upd_done) begin
          state_nxt = fsw_idle;
        end
      end
      fsw_job: begin
        if (job_done_in) begin
          state_nxt = fsw_idle;
        end
      end
      default: state_nxt = fsw_idle;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= fsw_idle;
    end else if (ce_in) begin
      state_r <= state_nxt; // RL8
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      upd_tmr_r <= 16'h0000;
    end else if (ce_in) begin
      if (upd_ok) begin
        upd_tmr_r <= UPD_CYCLES[15:0];
      end else if (upd_tmr_r != 16'h0000) begin
        upd_tmr_r <= upd_tmr_r - 16'h0001;
      end
    end
  end

  // completion only happens while busy and the unlock is only taken
  // while idle, so set and clear never meet in one cycle
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      latch_r <= 1'b0; // RL3
    end else if (ce_in) begin
      if (cmd_unlock && idle) begin
        latch_r <= 1'b1; // RL4
      end else if ((cmd_lock && idle) || upd_done || job_done) begin
        latch_r <= 1'b0; // RL1 RL3
      end
    end
  end

  // registers are committed at the start of the self-timed cycle; the
  // data byte never touches latch, busy or error flags
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      guard_r <= `FSW_GUARD_RST; // RL12
      lock_r <= 1'b0;
      cfg_r <= `FSW_CONFIG_RST; // RL19
    end else if (ce_in && upd_ok) begin
      if (lk_cnt_r == `FSW_CNT_ONE_BYTE) begin
        guard_r <= lk_pl_r[`FSW_BIT_GUARD_HI:`FSW_BIT_GUARD_LO]; // RL10
        lock_r <= lk_pl_r[`FSW_BIT_LOCK];
      end else begin
        guard_r <= lk_pl_r[8+`FSW_BIT_GUARD_HI:8+`FSW_BIT_GUARD_LO]; // RL10
        lock_r <= lk_pl_r[8+`FSW_BIT_LOCK];
        cfg_r <= lk_pl_r[7:0]; // RL20
      end
    end
  end

  assign job_is_prog = (job_kind_r == fsw_job_page) ||
                       (job_kind_r == fsw_job_quad) ||
                       (job_kind_r == fsw_job_ota);

  // a failure reported in the clear cycle survives the clear
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      perr_r <= 1'b0;
      eerr_r <= 1'b0;
    end else if (ce_in) begin
      if (job_done && job_fail_in && job_is_prog) begin
        perr_r <= 1'b1; // RL14
      end else if (cmd_clear) begin
        perr_r <= 1'b0; // RL14
      end
      if (job_done && job_fail_in && !job_is_prog) begin
        eerr_r <= 1'b1; // RL13
      end else if (cmd_clear) begin
        eerr_r <= 1'b0; // RL13
      end
    end
  end

  // engine handshake and register view
  assign job_go_out = job_go_r;
  assign job_kind_out = job_kind_r;
  assign job_addr_out = job_addr_r;
  assign config_out = cfg_r;
  assign hw_lock_state_out = hw_lock;

  assign flash_state_flags_out = {lock_r, perr_r, eerr_r, guard_r,
                                  latch_r, !idle}; // RL8 RL9 RL21

endmodule // fsw_core

// >>> tb/fsw_core_props.sv
// port-level checks of the flash status and write latch block
module fsw_core_props (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // watched ports
  input wire logic cs_b_in,
  input wire logic write_protect_pin_b_in,
  input wire logic so_oe_out,
  input wire logic job_go_out,
  input wire logic [2:0] job_kind_out,
  input wire logic addr_guarded_in,
  input wire logic job_done_in,
  input wire logic job_fail_in,
  input wire logic [7:0] flash_state_flags_out,
  input wire logic hw_lock_state_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] f;
  assign f = flash_state_flags_out;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_b_in);
  // four cycles cover the two-flop pin synchroniser
  a_lock_enters: assert property ((!write_protect_pin_b_in && f[7]) [*4]
    |-> hw_lock_state_out) else $error("lock not entered");
  a_lock_leaves: assert property (write_protect_pin_b_in [*4]
    |-> !hw_lock_state_out) else $error("lock not left");
  a_no_lock_bit: assert property (!f[7] |-> !hw_lock_state_out)
    else $error("lock without lock bit");
  a_fields_held: assert property ($changed({f[7], f[4:2]})
    |-> !$past(hw_lock_state_out)) else $error("locked field moved");
  a_go_ready: assert property (job_go_out |-> f[1] && !$past(f[0]))
    else $error("job started without latch");
  a_go_busy: assert property (job_go_out |-> f[0] [*3])
    else $error("busy missing during job");
  a_whole_clear: assert property (job_go_out && job_kind_out == 3'h6
    |-> f[4:2] == 3'h0) else $error("whole wipe under guard");
  a_go_unguarded: assert property (job_go_out && job_kind_out != 3'h2
    && job_kind_out != 3'h6 |-> !$past(addr_guarded_in))
    else $error("guarded job started");
  a_done_ends: assert property (job_done_in && f[0] |=> !f[0] && !f[1])
    else $error("job end kept busy or latch");
  a_prog_fail: assert property (job_done_in && job_fail_in && f[0]
    && job_kind_out <= 3'h2 |=> f[6]) else $error("program error lost");
  a_erase_fail: assert property (job_done_in && job_fail_in && f[0]
    && job_kind_out > 3'h2 |=> f[5]) else $error("erase error lost");
  a_err_cause: assert property ($rose(f[6]) || $rose(f[5])
    |-> $past(job_done_in && job_fail_in)) else $error("stray error");
  a_oe_select: assert property (cs_b_in |-> !so_oe_out)
    else $error("output driven while deselected");
endmodule // fsw_core_props

bind fsw_core fsw_core_props u_props (
  .clock_in,
  .rst_b_in,
  .cs_b_in,
  .write_protect_pin_b_in,
  .so_oe_out,
  .job_go_out,
  .job_kind_out,
  .addr_guarded_in,
  .job_done_in,
  .job_fail_in,
  .flash_state_flags_out,
  .hw_lock_state_out
);

// >>> tb/fsw_host_model.sv
// host serial controller model driving the link pins
module fsw_host_model (
  // link pins
  output logic sck_out,
  output logic cs_b_out,
  output logic si_out,
  input wire logic so_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sck_out = 1'b0;
    cs_b_out = 1'b1;
    si_out = 1'b0;
  end
  // serial clock only runs inside a frame
  task automatic xfer(input logic [31:0] b, input int n,
                      output logic [15:0] rd);
    // non-blocking so a change that lands on a clock edge is seen after it
    rd = 16'h0;
    cs_b_out <= 1'b0;
    for (int i = 0; i < n; i++) begin
      si_out <= b[31-i];
      #7.5 sck_out <= 1'b1;
      rd = {rd[14:0], so_in};
      #7.5 sck_out <= 1'b0;
    end
    #7.5 cs_b_out <= 1'b1;
    // released line has no pull, so show the opposite level
    si_out <= ~si_out;
    #40;
  endtask
endmodule // fsw_host_model

// >>> tb/tb_flash_status_write_latch.sv
// self-checking bench for the flash status and write latch block
`include "fsw_cfg.svh"

module tb_flash_status_write_latch;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] UNL = `FSW_OP_WRITE_UNLOCK;
  localparam logic [7:0] UPO = `FSW_OP_REGISTER_UPDATE;
  localparam logic [7:0] OPS [7] = '{8'h02, 8'h32, 8'h42, 8'h20, 8'h40,
    8'hD8, 8'hC7};
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic ce_in = 1'b1;
  logic wp_b = 1'b1;
  logic guarded = 1'b0;
  logic done = 1'b0;
  logic fail = 1'b0;
  logic sck, cs_b, si, so, oe, go, hwl, pe, ee, jf;
  logic so_line;
  logic [2:0] kind, go_kind;
  logic [23:0] addr, go_addr;
  logic [7:0] flags, cfg;
  logic [15:0] v;
  int go_cnt = 0;
  int bad_count = 0;
  int tests_run = 0;

  always #2.5 clock_in = ~clock_in;

  // undriven output shows the inverse level, as nothing pulls it
  assign so_line = oe ? so : ~so;

  fsw_core #(.UPD_CYCLES(100)) dut (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .sck_in(sck),
    .cs_b_in(cs_b),
    .si_in(si),
    .so_out(so),
    .so_oe_out(oe),
    .write_protect_pin_b_in(wp_b),
    .job_go_out(go),
    .job_kind_out(kind),
    .job_addr_out(addr),
    .addr_guarded_in(guarded),
    .job_done_in(done),
    .job_fail_in(fail),
    .flash_state_flags_out(flags),
    .config_out(cfg),
    .hw_lock_state_out(hwl)
  );

  fsw_host_model host (
    .sck_out(sck),
    .cs_b_out(cs_b),
    .si_out(si),
    .so_in(so_line)
  );

  // engine side: record every job start
  always @(posedge clock_in) begin
    if (go === 1'b1) begin
      go_cnt <= go_cnt + 1;
      go_kind <= kind;
      go_addr <= addr;
    end
  end

  task automatic chk(input string n, input logic [23:0] e,
                     input logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmd(input logic [31:0] b, input int n);
    host.xfer(b, n, v);
  endtask

  // two status bytes in one frame must match
  task automatic rd_st(input logic [7:0] e);
    cmd({`FSW_OP_STATE_READ, 24'h0}, 24);
    chk("status", {8'h0, e, e}, 24'(v));
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 40; i++) begin
      cmd({`FSW_OP_STATE_READ, 24'h0}, 16);
      if (v[0] === 1'b0) begin
        return;
      end
    end
    chk("idle", 24'h0, 24'h1);
  endtask

  task automatic job(input logic [2:0] k, input logic [7:0] e);
    int c;
    c = go_cnt;
    cmd({UNL, 24'h0}, 8);
    cmd({OPS[k], 24'h00A5C3}, (k == 3'h6) ? 8 : 32);
    chk("job go", 24'(c + 1), 24'(go_cnt));
    chk("job kind", 24'(k), 24'(go_kind));
    if (k != 3'h6) begin
      chk("job addr", 24'h00A5C3, go_addr);
    end
    @(posedge clock_in);
    done <= 1'b1;
    fail <= jf;
    @(posedge clock_in);
    done <= 1'b0;
    rd_st(e);
  endtask

  task automatic complete_run();
    if (bad_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clock_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    chk("flags", 24'h0, 24'(flags));
    cmd({`FSW_OP_CONFIG_READ, 24'h0}, 16);
    chk("config", 24'h0, 24'(v[7:0]));
    cmd({UPO, 8'h9C, 16'h0}, 16);
    rd_st(8'h00);
    cmd({UNL, 24'h0}, 8);
    rd_st(8'h02);
    cmd({`FSW_OP_WRITE_LOCK, 24'h0}, 8);
    cmd({8'h02, 24'h00A5C3}, 32);
    rd_st(8'h00);
    cmd({UNL, 24'h0}, 8);
    cmd({UPO, 8'h9C, 16'h0}, 16);
    rd_st(8'h9F);
    wait_idle();
    rd_st(8'h9C);
    cmd({UNL, 24'h0}, 8);
    cmd({8'hC7, 24'h0}, 8);
    rd_st(8'h9E);
    @(posedge clock_in);
    wp_b <= 1'b0;
    repeat (4) @(posedge clock_in);
    chk("hw lock", 24'h1, 24'(hwl));
    cmd({UPO, 24'h0}, 16);
    rd_st(8'h9E);
    @(posedge clock_in);
    wp_b <= 1'b1;
    repeat (4) @(posedge clock_in);
    cmd({UPO, 16'h005A, 8'h0}, 24);
    wait_idle();
    rd_st(8'h00);
    cmd({`FSW_OP_CONFIG_READ, 24'h0}, 24);
    chk("config", 24'h5A5A, 24'(v));
    chk("config reg", 24'h5A, 24'(cfg));
    // a frame that ends while frozen is never taken
    @(posedge clock_in);
    ce_in <= 1'b0;
    cmd({UNL, 24'h0}, 8);
    chk("frozen flags", 24'h0, 24'(flags));
    @(posedge clock_in);
    ce_in <= 1'b1;
    @(posedge clock_in);
    wp_b <= 1'b0;
    cmd({UNL, 24'h0}, 8);
    chk("hw lock", 24'h0, 24'(hwl));
    cmd({UPO, 8'h1C, 16'h0}, 20);
    rd_st(8'h02);
    cmd({UPO, 8'h08, 16'h0}, 16);
    wait_idle();
    rd_st(8'h08);
    @(posedge clock_in);
    guarded <= 1'b1;
    cmd({UNL, 24'h0}, 8);
    cmd({8'h02, 24'h00A5C3}, 32);
    rd_st(8'h0A);
    chk("refused go", 24'h0, 24'(go_cnt));
    cmd({UPO, 24'h0}, 16);
    wait_idle();
    @(posedge clock_in);
    guarded <= 1'b0;
    wp_b <= 1'b1;
    pe = 1'b0;
    ee = 1'b0;
    // failures on one program and one erase kind, flags must stick
    for (int k = 0; k < 7; k++) begin
      jf = (k == 0) || (k == 4);
      pe = pe | (jf & (k < 3));
      ee = ee | (jf & (k > 2));
      job(3'(k), {1'b0, pe, ee, 5'h0});
    end
    cmd({`FSW_OP_FLAG_CLEAR, 24'h0}, 8);
    rd_st(8'h00);
    cmd({UNL, 24'h0}, 8);
    chk("unlocked", 24'h02, 24'(flags));
    // second power-up in mid-run must drop the latch and registers
    @(posedge clock_in);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    chk("reset flags", 24'h0, 24'(flags));
    chk("reset config", 24'h0, 24'(cfg));
    complete_run();
  end

  initial begin
    #400000;
    bad_count++;
    complete_run();
  end
endmodule // tb_flash_status_write_latch
